/* lookup_ctl_pkg.sv */
/*
 * Constants and carrier types of the lookup index and forwarding bank.
 * Assumes byte-wide host access and one clock domain.
 */
package lookup_ctl_pkg;

    // ----------------
    // register byte addresses
    // ----------------
    localparam logic [15:0] IDX0_ADDR       = 16'h0316;
    localparam logic [15:0] IDX1_ADDR       = 16'h0318;
    localparam logic [15:0] IDX2_ADDR       = 16'h031A;
    localparam logic [15:0] UCAST_CTL_ADDR  = 16'h0320;
    localparam logic [15:0] MCAST_CTL_ADDR  = 16'h0324;
    localparam logic [15:0] VLAN_CTL_ADDR   = 16'h0328;
    localparam logic [15:0] IDX_SPAN        = 16'h0002;
    localparam logic [15:0] CTL_SPAN        = 16'h0004;

    // ----------------
    // field layout
    // ----------------
    localparam int ENTRY_IDX_W    = 12;
    localparam int BUCKET_IDX_W   = 10;
    localparam int PORT_MASK_W    = 7;
    localparam int STATIC_CNT_W   = 3;
    localparam int CTL_ENABLE_BIT = 31;
    localparam int CTL_MASK_LSB   = 0;

    // ----------------
    // reset values and bucket thresholds
    // ----------------
    localparam logic [ENTRY_IDX_W-1:0]  ENTRY_IDX_RST  = 12'h000;
    localparam logic [BUCKET_IDX_W-1:0] BUCKET_IDX_RST = 10'h000;
    localparam logic [PORT_MASK_W-1:0]  PORT_MASK_RST  = 7'h00;
    localparam logic                    CTL_ENABLE_RST = 1'b0;
    localparam logic [STATIC_CNT_W-1:0] ALMOST_FULL_LO = 3'h2;
    localparam logic [STATIC_CNT_W-1:0] ALMOST_FULL_HI = 3'h3;
    localparam logic [STATIC_CNT_W-1:0] BUCKET_FULL    = 3'h4;
    localparam logic [7:0]              UNMAPPED_DATA  = 8'h00;

    // ----------------
    // carriers
    // ----------------
    typedef struct packed {
        logic                    valid;
        logic                    ok;
        logic [ENTRY_IDX_W-1:0]  entry_addr;
        logic [BUCKET_IDX_W-1:0] bucket_addr;
        logic [STATIC_CNT_W-1:0] prior_static;
    } static_write_evt_t;

    typedef struct packed {
        logic                    valid;
        logic [BUCKET_IDX_W-1:0] bucket_addr;
        logic [STATIC_CNT_W-1:0] static_count;
    } learn_evt_t;

    typedef struct packed {
        logic                    valid;
        logic [BUCKET_IDX_W-1:0] bucket_addr;
    } host_access_evt_t;

    typedef struct packed {
        logic                   enable;
        logic [PORT_MASK_W-1:0] ports;
    } fwd_ctl_t;

    typedef struct packed {
        logic                   valid;
        logic                   unk_vlan;
        logic                   unk_ucast;
        logic                   unk_mcast;
        logic [PORT_MASK_W-1:0] table_ports;
    } frame_class_t;

    typedef enum logic [1:0] {
        SRC_TABLE,
        SRC_VLAN,
        SRC_UCAST,
        SRC_MCAST
    } fwd_src_t;

    typedef struct packed {
        logic                   valid;
        fwd_src_t               source;
        logic [PORT_MASK_W-1:0] ports;
    } fwd_result_t;

endpackage

/* unknown_fwd_resolver.sv */
/*
 * Forwarding port map choice for one classified frame.
 * Assumes the caller registers the result.
 */
`timescale 1ns/1ps
module unknown_fwd_resolver #(
    parameter int PORT_COUNT = 7
) (
    input  lookup_ctl_pkg::frame_class_t frame,
    input  lookup_ctl_pkg::fwd_ctl_t     vlan_ctl,
    input  lookup_ctl_pkg::fwd_ctl_t     ucast_ctl,
    input  lookup_ctl_pkg::fwd_ctl_t     mcast_ctl,
    output lookup_ctl_pkg::fwd_result_t  result
);

    localparam logic [lookup_ctl_pkg::PORT_MASK_W-1:0] PORT_LIMIT =
        lookup_ctl_pkg::PORT_MASK_W'((1 << PORT_COUNT) - 1);

    initial begin
        if (PORT_COUNT < 1 || PORT_COUNT > lookup_ctl_pkg::PORT_MASK_W) begin
            $error("PORT_COUNT out of range");
        end
    end

    // ------------------------------------------------------------
    // precedence: the highest category a frame falls into decides
    // ------------------------------------------------------------
    always_comb begin
        result.valid  = frame.valid;
        result.source = lookup_ctl_pkg::SRC_TABLE;
        result.ports  = frame.table_ports & PORT_LIMIT;
        if (frame.unk_vlan) begin                                       // RULE5
            if (vlan_ctl.enable) begin                                  // RULE12 RULE14
                result.source = lookup_ctl_pkg::SRC_VLAN;
                result.ports  = vlan_ctl.ports & PORT_LIMIT;            // RULE13
            end
        end else if (frame.unk_ucast) begin                             // RULE5
            if (ucast_ctl.enable) begin                                 // RULE6 RULE8
                result.source = lookup_ctl_pkg::SRC_UCAST;
                result.ports  = ucast_ctl.ports & PORT_LIMIT;           // RULE7
            end
        end else if (frame.unk_mcast) begin                             // RULE5
            if (mcast_ctl.enable) begin                                 // RULE9 RULE11
                result.source = lookup_ctl_pkg::SRC_MCAST;
                result.ports  = mcast_ctl.ports & PORT_LIMIT;           // RULE10
            end
        end
    end

endmodule

/* lookup_index_regs.sv */
/*
 * Lookup index and unknown-destination forwarding registers, byte access.
 * Assumes all inputs come from logic on REF_CLK, so none is synchronised.
 */
// Contract
// RULE1: almost-full static write records entry address
// RULE2: failed static write records bucket address
// RULE3: learn fail on four statics records bucket
// RULE4: every host table access records bucket
// RULE5: precedence: vlan, then unicast, then multicast
// RULE6: unicast enable forwards unknown unicast by mask
// RULE7: unicast mask bit 0 is port 1
// RULE8: unicast enable clear disables mask forwarding
// RULE9: multicast enable forwards unknown multicast by mask
// RULE10: multicast mask bit 0 is port 1
// RULE11: multicast enable clear disables mask forwarding
// RULE12: vlan enable forwards unknown vlan by mask
// RULE13: vlan mask bit 0 is port 1
// RULE14: vlan enable clear disables mask forwarding
// RULE15: almost-full write raises almost-full flag
// RULE16: indexes hold, ignore writes, reserved read zero
`timescale 1ns/1ps
module lookup_index_regs #(
    parameter int PORT_COUNT = 7
) (
    input  wire logic                              REF_CLK,
    input  wire logic                              RST_N,
    input  wire logic                              CE,
    input  wire logic [15:0]                       REG_ADDR,
    input  wire logic                              REG_WR,
    input  wire logic                              REG_RD,
    input  wire logic [7:0]                        REG_WDATA,
    output logic      [7:0]                        REG_RDATA,
    output logic                                   REG_RVALID,
    input  lookup_ctl_pkg::static_write_evt_t      STATIC_WR,
    input  lookup_ctl_pkg::learn_evt_t             LEARN_FAIL,
    input  lookup_ctl_pkg::host_access_evt_t       HOST_ACCESS,
    input  lookup_ctl_pkg::frame_class_t           FRAME_IN,
    output lookup_ctl_pkg::fwd_result_t            FWD_OUT,
    output logic                                   ALMOST_FULL,
    output logic                                   WRITE_FAIL,
    output logic                                   LEARN_FAILED
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [lookup_ctl_pkg::ENTRY_IDX_W-1:0]  entry_idx_q;
    logic [lookup_ctl_pkg::BUCKET_IDX_W-1:0] learn_idx_q;
    logic [lookup_ctl_pkg::BUCKET_IDX_W-1:0] host_idx_q;
    lookup_ctl_pkg::fwd_ctl_t                ucast_ctl_q;
    lookup_ctl_pkg::fwd_ctl_t                mcast_ctl_q;
    lookup_ctl_pkg::fwd_ctl_t                vlan_ctl_q;
    lookup_ctl_pkg::fwd_ctl_t                ucast_ctl_d;
    lookup_ctl_pkg::fwd_ctl_t                mcast_ctl_d;
    lookup_ctl_pkg::fwd_ctl_t                vlan_ctl_d;
    lookup_ctl_pkg::fwd_result_t             fwd_d;
    logic [7:0]                              rdata_d;
    logic [1:0]                              reg_lane;
    logic                                    almost_full_evt;
    logic                                    write_fail_evt;
    logic                                    learn_fail_evt;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // true when addr falls in [base, base+span)
    function automatic logic in_reg(input logic [15:0] addr,
                                    input logic [15:0] base,
                                    input logic [15:0] span);
        in_reg = (addr >= base) && (addr < 16'(base + span));
    endfunction

    // bases are aligned to their width; lane 0 is the top byte
    assign reg_lane = REG_ADDR[1:0];

    // 32-bit image of a forwarding control, reserved bits zero
    function automatic logic [31:0] ctl_image(input lookup_ctl_pkg::fwd_ctl_t ctl);
        logic [31:0] img;
        img                                  = 32'h0000_0000;
        img[lookup_ctl_pkg::CTL_ENABLE_BIT]  = ctl.enable;
        img[lookup_ctl_pkg::CTL_MASK_LSB +: lookup_ctl_pkg::PORT_MASK_W] = ctl.ports;
        ctl_image = img;
    endfunction

    // byte of a 32-bit image, lane 0 is bits 31:24
    function automatic logic [7:0] byte32(input logic [31:0] img,
                                          input logic [1:0]  lane);
        logic [7:0] b;
        b = 8'h00;
        case (lane)
            2'h0:    b = img[31:24];
            2'h1:    b = img[23:16];
            2'h2:    b = img[15:8];
            2'h3:    b = img[7:0];
            default: b = 8'h00;
        endcase
        byte32 = b;
    endfunction

    // byte of a 16-bit image, lane 0 is bits 15:8
    function automatic logic [7:0] byte16(input logic [15:0] img,
                                          input logic [1:0]  lane);
        byte16 = lane[0] ? img[7:0] : img[15:8];
    endfunction

    // apply a byte write to one forwarding control; reserved lanes drop
    function automatic lookup_ctl_pkg::fwd_ctl_t ctl_write(
        input lookup_ctl_pkg::fwd_ctl_t ctl,
        input logic [1:0]               lane,
        input logic [7:0]               data
    );
        lookup_ctl_pkg::fwd_ctl_t nxt;
        nxt = ctl;
        case (lane)
            2'h0:    nxt.enable = data[lookup_ctl_pkg::CTL_ENABLE_BIT - 24];
            2'h3:    nxt.ports  = data[lookup_ctl_pkg::PORT_MASK_W-1:0];
            default: nxt = ctl;
        endcase
        ctl_write = nxt;
    endfunction

    // ------------------------------------------------------------
    // lookup engine event decode
    // ------------------------------------------------------------
    assign almost_full_evt = STATIC_WR.valid && STATIC_WR.ok &&
                             (STATIC_WR.prior_static == lookup_ctl_pkg::ALMOST_FULL_LO ||
                              STATIC_WR.prior_static == lookup_ctl_pkg::ALMOST_FULL_HI);
    assign write_fail_evt  = STATIC_WR.valid && !STATIC_WR.ok;
    assign learn_fail_evt  = LEARN_FAIL.valid &&
                             (LEARN_FAIL.static_count == lookup_ctl_pkg::BUCKET_FULL);

    // ------------------------------------------------------------
    // almost-full / fail-write index
    // ------------------------------------------------------------
    // both events share one field; the last one seen stands
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            entry_idx_q <= lookup_ctl_pkg::ENTRY_IDX_RST;
        end else if (CE) begin
            if (almost_full_evt) begin
                entry_idx_q <= STATIC_WR.entry_addr;                          // RULE1
            end else if (write_fail_evt) begin
                entry_idx_q <= lookup_ctl_pkg::ENTRY_IDX_W'(STATIC_WR.bucket_addr); // RULE2
            end
        end
    end

    // ------------------------------------------------------------
    // learn-failure index
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            learn_idx_q <= lookup_ctl_pkg::BUCKET_IDX_RST;
        end else if (CE && learn_fail_evt) begin
            learn_idx_q <= LEARN_FAIL.bucket_addr;                            // RULE3
        end
    end

    // ------------------------------------------------------------
    // host-access index
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            host_idx_q <= lookup_ctl_pkg::BUCKET_IDX_RST;
        end else if (CE && HOST_ACCESS.valid) begin
            host_idx_q <= HOST_ACCESS.bucket_addr;                            // RULE4
        end
    end

    // ------------------------------------------------------------
    // event flags toward the interrupt logic
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            ALMOST_FULL  <= 1'b0;
            WRITE_FAIL   <= 1'b0;
            LEARN_FAILED <= 1'b0;
        end else if (CE) begin
            ALMOST_FULL  <= almost_full_evt;                                  // RULE15
            WRITE_FAIL   <= write_fail_evt;
            LEARN_FAILED <= learn_fail_evt;
        end
    end

    // ------------------------------------------------------------
    // forwarding control writes
    // ------------------------------------------------------------
    // index registers have no write path at all
    always_comb begin
        ucast_ctl_d = ucast_ctl_q;
        mcast_ctl_d = mcast_ctl_q;
        vlan_ctl_d  = vlan_ctl_q;
        if (REG_WR) begin                                                     // RULE16
            if (in_reg(REG_ADDR, lookup_ctl_pkg::UCAST_CTL_ADDR, lookup_ctl_pkg::CTL_SPAN)) begin
                ucast_ctl_d = ctl_write(ucast_ctl_q, reg_lane, REG_WDATA);
            end
            if (in_reg(REG_ADDR, lookup_ctl_pkg::MCAST_CTL_ADDR, lookup_ctl_pkg::CTL_SPAN)) begin
                mcast_ctl_d = ctl_write(mcast_ctl_q, reg_lane, REG_WDATA);
            end
            if (in_reg(REG_ADDR, lookup_ctl_pkg::VLAN_CTL_ADDR, lookup_ctl_pkg::CTL_SPAN)) begin
                vlan_ctl_d = ctl_write(vlan_ctl_q, reg_lane, REG_WDATA);
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            ucast_ctl_q.enable <= lookup_ctl_pkg::CTL_ENABLE_RST;             // RULE8
            ucast_ctl_q.ports  <= lookup_ctl_pkg::PORT_MASK_RST;
            mcast_ctl_q.enable <= lookup_ctl_pkg::CTL_ENABLE_RST;             // RULE11
            mcast_ctl_q.ports  <= lookup_ctl_pkg::PORT_MASK_RST;
            vlan_ctl_q.enable  <= lookup_ctl_pkg::CTL_ENABLE_RST;             // RULE14
            vlan_ctl_q.ports   <= lookup_ctl_pkg::PORT_MASK_RST;
        end else if (CE) begin
            ucast_ctl_q <= ucast_ctl_d;
            mcast_ctl_q <= mcast_ctl_d;
            vlan_ctl_q  <= vlan_ctl_d;
        end
    end

    // ------------------------------------------------------------
    // register read mux
    // ------------------------------------------------------------
    always_comb begin
        rdata_d = lookup_ctl_pkg::UNMAPPED_DATA;
        if (in_reg(REG_ADDR, lookup_ctl_pkg::IDX0_ADDR, lookup_ctl_pkg::IDX_SPAN)) begin
            rdata_d = byte16(16'(entry_idx_q), reg_lane);                     // RULE16
        end else if (in_reg(REG_ADDR, lookup_ctl_pkg::IDX1_ADDR, lookup_ctl_pkg::IDX_SPAN)) begin
            rdata_d = byte16(16'(learn_idx_q), reg_lane);
        end else if (in_reg(REG_ADDR, lookup_ctl_pkg::IDX2_ADDR, lookup_ctl_pkg::IDX_SPAN)) begin
            rdata_d = byte16(16'(host_idx_q), reg_lane);
        end else if (in_reg(REG_ADDR, lookup_ctl_pkg::UCAST_CTL_ADDR, lookup_ctl_pkg::CTL_SPAN)) begin
            rdata_d = byte32(ctl_image(ucast_ctl_q), reg_lane);
        end else if (in_reg(REG_ADDR, lookup_ctl_pkg::MCAST_CTL_ADDR, lookup_ctl_pkg::CTL_SPAN)) begin
            rdata_d = byte32(ctl_image(mcast_ctl_q), reg_lane);
        end else if (in_reg(REG_ADDR, lookup_ctl_pkg::VLAN_CTL_ADDR, lookup_ctl_pkg::CTL_SPAN)) begin
            rdata_d = byte32(ctl_image(vlan_ctl_q), reg_lane);
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            REG_RDATA  <= 8'h00;
            REG_RVALID <= 1'b0;
        end else if (CE) begin
            REG_RVALID <= REG_RD;
            if (REG_RD) begin
                REG_RDATA <= rdata_d;
            end
        end
    end

    // ------------------------------------------------------------
    // unknown-destination forwarding
    // ------------------------------------------------------------
    unknown_fwd_resolver #(
        .PORT_COUNT (PORT_COUNT)
    ) i_unknown_fwd_resolver (
        .frame     (FRAME_IN),
        .vlan_ctl  (vlan_ctl_q),
        .ucast_ctl (ucast_ctl_q),
        .mcast_ctl (mcast_ctl_q),
        .result    (fwd_d)
    );

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            FWD_OUT.valid  <= 1'b0;
            FWD_OUT.source <= lookup_ctl_pkg::SRC_TABLE;
            FWD_OUT.ports  <= lookup_ctl_pkg::PORT_MASK_RST;
        end else if (CE) begin
            FWD_OUT.valid <= fwd_d.valid;                                     // RULE5
            if (fwd_d.valid) begin
                FWD_OUT.source <= fwd_d.source;
                FWD_OUT.ports  <= fwd_d.ports;
            end
        end
    end

endmodule

/* lookup_index_regs_asserts.sv */
/*
 * Port-level checks for the lookup index and unknown forwarding bank.
 * Assumes one domain on REF_CLK with synchronous active-low RST_N.
 */
`timescale 1ns/1ps
module lookup_index_regs_asserts #(
    parameter int PORT_COUNT = 7
) (
    input wire logic                         REF_CLK,
    input wire logic                         RST_N,
    input wire logic                         CE,
    input wire logic [15:0]                  REG_ADDR,
    input wire logic                         REG_WR,
    input wire logic                         REG_RD,
    input wire logic [7:0]                   REG_WDATA,
    input wire logic [7:0]                   REG_RDATA,
    input wire logic                         REG_RVALID,
    input lookup_ctl_pkg::static_write_evt_t STATIC_WR,
    input lookup_ctl_pkg::learn_evt_t        LEARN_FAIL,
    input lookup_ctl_pkg::host_access_evt_t  HOST_ACCESS,
    input lookup_ctl_pkg::frame_class_t      FRAME_IN,
    input lookup_ctl_pkg::fwd_result_t       FWD_OUT,
    input wire logic                         ALMOST_FULL,
    input wire logic                         WRITE_FAIL,
    input wire logic                         LEARN_FAILED
);
    logic near_full_in;
    logic fail_wr_in;
    logic learn_in;
    logic ctl_mid;
    assign near_full_in = STATIC_WR.valid && STATIC_WR.ok && STATIC_WR.prior_static inside {3'h2, 3'h3};
    assign fail_wr_in = STATIC_WR.valid && !STATIC_WR.ok;
    assign learn_in = LEARN_FAIL.valid && LEARN_FAIL.static_count == 3'h4;
    assign ctl_mid = REG_ADDR inside {16'h0321, 16'h0322, 16'h0325, 16'h0326, 16'h0329, 16'h032A};

    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RST_N);

    sequence s_read(logic [15:0] a);
        CE && REG_RD && REG_ADDR == a;
    endsequence
    sequence s_frame;
        CE && FRAME_IN.valid;
    endsequence

    a_almost_full_flag: assert property (CE |=> ALMOST_FULL == $past(near_full_in))
        else $error("almost-full flag mismatch");
    a_write_fail_flag: assert property (CE |=> WRITE_FAIL == $past(fail_wr_in))
        else $error("write-fail flag mismatch");
    a_learn_fail_flag: assert property (CE |=> LEARN_FAILED == $past(learn_in))
        else $error("learn-fail flag mismatch");
    a_read_answer: assert property (CE |=> REG_RVALID == $past(REG_RD))
        else $error("read valid mismatch");
    a_idx0_upper_zero: assert property (s_read(16'h0316) |=> REG_RDATA[7:4] == 4'h0)
        else $error("index 0 reserved bits set");
    a_idx_upper_zero: assert property (CE && REG_RD && REG_ADDR inside {16'h0318, 16'h031A} |=> REG_RDATA[7:2] == 6'h00)
        else $error("index reserved bits set");
    a_ctl_mid_zero: assert property (CE && REG_RD && ctl_mid |=> REG_RDATA == 8'h00)
        else $error("control reserved byte not zero");
    a_vlan_first: assert property (s_frame ##0 FRAME_IN.unk_vlan |=>
        FWD_OUT.source inside {lookup_ctl_pkg::SRC_VLAN, lookup_ctl_pkg::SRC_TABLE})
        else $error("unknown vlan not handled first");
    a_ucast_next: assert property (s_frame ##0 (!FRAME_IN.unk_vlan && FRAME_IN.unk_ucast) |=>
        FWD_OUT.source inside {lookup_ctl_pkg::SRC_UCAST, lookup_ctl_pkg::SRC_TABLE})
        else $error("unknown unicast not handled second");
    a_table_pass: assert property (s_frame ##0 !(FRAME_IN.unk_vlan || FRAME_IN.unk_ucast || FRAME_IN.unk_mcast) |=>
        FWD_OUT.source == lookup_ctl_pkg::SRC_TABLE && FWD_OUT.ports == $past(FRAME_IN.table_ports))
        else $error("known frame did not keep table ports");
    a_frame_answer: assert property (CE |=> FWD_OUT.valid == $past(FRAME_IN.valid))
        else $error("forward valid mismatch");
    a_freeze_hold: assert property (!CE |=> $stable(FWD_OUT) && $stable(REG_RDATA) && $stable(REG_RVALID))
        else $error("outputs moved with clock enable low");
endmodule

bind lookup_index_regs lookup_index_regs_asserts #(.PORT_COUNT(PORT_COUNT)) i_lookup_index_regs_asserts (.*);

/* lookup_index_and_unknown_forwarding_tb_top.sv */
/*
 * Self-checking bench for the lookup index and unknown forwarding bank.
 * Assumes the package is compiled first and the checker is bound.
 */
`timescale 1ns/1ps
module lookup_index_and_unknown_forwarding_tb_top;
    logic                              ref_clk = 1'b0;
    logic                              rst_n = 1'b0;
    logic                              ce = 1'b1;
    logic [15:0]                       addr = 16'h0000;
    logic                              wr = 1'b0;
    logic                              rd = 1'b0;
    logic [7:0]                        wdata = 8'h00;
    logic [7:0]                        rdata;
    logic                              rvalid;
    lookup_ctl_pkg::static_write_evt_t sw = '0;
    lookup_ctl_pkg::learn_evt_t        lf = '0;
    lookup_ctl_pkg::host_access_evt_t  ha = '0;
    lookup_ctl_pkg::frame_class_t      fr = '0;
    lookup_ctl_pkg::fwd_result_t       fo;
    logic                              af;
    logic                              wf;
    logic                              lfl;
    int                                err_total = 0;
    int                                n_compared = 0;

    always #25 ref_clk = ~ref_clk;

    lookup_index_regs i_lookup_index_regs (.REF_CLK(ref_clk), .RST_N(rst_n), .CE(ce), .REG_ADDR(addr),
        .REG_WR(wr), .REG_RD(rd), .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RVALID(rvalid), .STATIC_WR(sw),
        .LEARN_FAIL(lf), .HOST_ACCESS(ha), .FRAME_IN(fr), .FWD_OUT(fo), .ALMOST_FULL(af), .WRITE_FAIL(wf),
        .LEARN_FAILED(lfl));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr8(input logic [15:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge ref_clk);
        wr = 1'b0;
    endtask
    task automatic rd8(input logic [15:0] a, input logic [7:0] exp);
        @(negedge ref_clk);
        addr = a;
        rd = 1'b1;
        @(negedge ref_clk);
        rd = 1'b0;
        chk("read valid", 16'h0001, {15'h0, rvalid});
        chk($sformatf("byte %h", a), {8'h00, exp}, {8'h00, rdata});
    endtask
    task automatic rd16(input logic [15:0] a, input logic [15:0] exp);
        rd8(a, exp[15:8]);
        rd8(a + 16'h0001, exp[7:0]);
    endtask
    task automatic settle(input logic [2:0] fl);
        @(negedge ref_clk);
        sw.valid = 1'b0;
        lf.valid = 1'b0;
        ha.valid = 1'b0;
        chk("event flags", {13'h0, fl}, {13'h0, af, wf, lfl});
    endtask
    task automatic frm(input logic [2:0] cat, input logic [6:0] tp, input logic [1:0] src, input logic [6:0] pm);
        @(negedge ref_clk);
        fr = {1'b1, cat, tp};
        @(negedge ref_clk);
        fr.valid = 1'b0;
        chk("forward valid", 16'h0001, {15'h0, fo.valid});
        chk("forward source", {14'h0, src}, {14'h0, fo.source});
        chk("forward ports", {9'h0, pm}, {9'h0, fo.ports});
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        for (int a = 16'h0316; a <= 16'h032B; a++)
            rd8(16'(a), 8'h00);
        $display("t_reset done");
    endtask
    task automatic t_index();
        @(negedge ref_clk);
        sw = {2'b11, 12'hABC, 10'h155, 3'h2};
        settle(3'b100);
        rd16(16'h0316, 16'h0ABC);
        @(negedge ref_clk);
        sw = {2'b11, 12'h123, 10'h000, 3'h3};
        settle(3'b100);
        @(negedge ref_clk);
        sw = {2'b11, 12'h555, 10'h000, 3'h1};
        settle(3'b000);
        rd16(16'h0316, 16'h0123);
        @(negedge ref_clk);
        sw = {2'b10, 12'h000, 10'h3FF, 3'h4};
        settle(3'b010);
        rd16(16'h0316, 16'h03FF);
        @(negedge ref_clk);
        lf = {1'b1, 10'h2A5, 3'h4};
        settle(3'b001);
        @(negedge ref_clk);
        lf = {1'b1, 10'h111, 3'h3};
        settle(3'b000);
        rd16(16'h0318, 16'h02A5);
        @(negedge ref_clk);
        ha = {1'b1, 10'h1C3};
        @(negedge ref_clk);
        ha = {1'b1, 10'h3C0};
        settle(3'b000);
        rd16(16'h031A, 16'h03C0);
        for (int a = 16'h0316; a <= 16'h031B; a++)
            wr8(16'(a), 8'hFF);
        rd16(16'h0316, 16'h03FF);
        rd16(16'h0318, 16'h02A5);
        @(negedge ref_clk);
        ce = 1'b0;
        ha = {1'b1, 10'h0AA};
        @(negedge ref_clk);
        ha.valid = 1'b0;
        ce = 1'b1;
        rd16(16'h031A, 16'h03C0);
        $display("t_index done");
    endtask
    task automatic t_ctl();
        logic [15:0] b;
        for (int i = 0; i < 3; i++) begin
            b = 16'h0320 + 16'(4 * i);
            for (int k = 0; k < 4; k++)
                wr8(b + 16'(k), 8'hFF);
            rd8(b, 8'h80);
            rd8(b + 16'h0001, 8'h00);
            rd8(b + 16'h0002, 8'h00);
            rd8(b + 16'h0003, 8'h7F);
        end
        $display("t_ctl done");
    endtask
    task automatic t_fwd();
        wr8(16'h0323, 8'h01);
        wr8(16'h0327, 8'h40);
        frm(3'b111, 7'h55, lookup_ctl_pkg::SRC_VLAN, 7'h7F);
        frm(3'b011, 7'h55, lookup_ctl_pkg::SRC_UCAST, 7'h01);
        frm(3'b001, 7'h55, lookup_ctl_pkg::SRC_MCAST, 7'h40);
        frm(3'b000, 7'h55, lookup_ctl_pkg::SRC_TABLE, 7'h55);
        wr8(16'h032B, 8'h00);
        frm(3'b100, 7'h55, lookup_ctl_pkg::SRC_VLAN, 7'h00);
        wr8(16'h0328, 8'h00);
        frm(3'b100, 7'h2A, lookup_ctl_pkg::SRC_TABLE, 7'h2A);
        frm(3'b110, 7'h2A, lookup_ctl_pkg::SRC_TABLE, 7'h2A);
        wr8(16'h0320, 8'h00);
        wr8(16'h0324, 8'h00);
        frm(3'b010, 7'h13, lookup_ctl_pkg::SRC_TABLE, 7'h13);
        frm(3'b001, 7'h64, lookup_ctl_pkg::SRC_TABLE, 7'h64);
        $display("t_fwd done");
    endtask

    task automatic end_of_test();
        $display("compared %0d mismatched %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        repeat (4000) @(posedge ref_clk);
        err_total++;
        end_of_test();
    end

    initial begin
        repeat (3) @(negedge ref_clk);
        rst_n = 1'b1;
        t_reset();
        t_index();
        t_ctl();
        t_fwd();
        end_of_test();
    end
endmodule
